/* File: pcs_pkg.sv */
/*
 * Constants for the configuration command/status doubleword block.
 * Assumes a configuration access port that presents one doubleword per
 * request, with byte enables, on the PCI clock.
 */
package pcs_pkg;

    // ****************************************
    // Register placement
    // ****************************************
    localparam logic [7:0] PCS_CMDSTAT_ADDR = 8'h04;

    // ****************************************
    // Command half bit positions
    // ****************************************
    localparam int PCS_B_IO_EN = 0;
    localparam int PCS_B_MEM_EN = 1;
    localparam int PCS_B_MASTER_EN = 2;
    localparam int PCS_B_PAR_RESP = 6;
    localparam int PCS_B_SERR_EN = 8;

    // ****************************************
    // Status half bit positions
    // ****************************************
    localparam int PCS_B_CAP_LIST = 20;
    localparam int PCS_B_TGT_FBB = 23;
    localparam int PCS_B_DATA_PERR = 24;
    localparam int PCS_B_DEVSEL_LO = 25;
    localparam int PCS_B_DEVSEL_HI = 26;
    localparam int PCS_B_MST_ABORT = 29;
    localparam int PCS_B_TGT_ABORT = 28;
    localparam int PCS_B_SIG_SERR = 30;
    localparam int PCS_B_DET_PERR = 31;

    // ****************************************
    // Sticky flag bank slots
    // ****************************************
    localparam int PCS_NFLAGS = 5;
    localparam int PCS_F_DATA_PERR = 0;
    localparam int PCS_F_TGT_ABORT = 1;
    localparam int PCS_F_MST_ABORT = 2;
    localparam int PCS_F_SIG_SERR = 3;
    localparam int PCS_F_DET_PERR = 4;

    // ****************************************
    // Fixed values
    // ****************************************
    localparam logic [1:0] PCS_DEVSEL_MEDIUM = 2'h1;
    localparam logic [1:0] PCS_DEVSEL_CLOCKS = 2'h2;
    localparam logic PCS_CAP_LIST_VAL = 1'b1;
    localparam logic PCS_TGT_FBB_VAL = 1'b1;
    localparam logic PCS_IO_EN_RST = 1'b1;
    localparam logic PCS_MEM_EN_RST = 1'b1;
    localparam logic PCS_MASTER_EN_RST = 1'b1;
    localparam logic PCS_PAR_RESP_RST = 1'b0;
    localparam logic PCS_SERR_EN_RST = 1'b0;
    localparam logic [3:0] PCS_CMD_MEM_WRITE = 4'h7;
    localparam logic [31:0] PCS_ZERO_WORD = 32'h0;

    typedef enum logic [2:0] {
        PCS_T_IDLE = 3'h1,
        PCS_T_WAIT = 3'h2,
        PCS_T_CLAIM = 3'h4
    } pcs_tgt_e;

endpackage : pcs_pkg

/* File: pcs_flag_if.sv */
/*
 * Carrier between the main block and its sticky flag bank.
 * Assumes both ends share the PCI clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface pcs_flag_if #(parameter int N = 5);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] flags;
    modport bank (input set, input clr, output flags);
    modport user (output set, output clr, input flags);
endinterface : pcs_flag_if
`default_nettype wire

/* File: pcs_flag_bank.sv */
/*
 * Bank of write-one-to-clear sticky status flags.
 * Assumes set and clear pulses are one clock wide and synchronous.
 */
`timescale 1ns/100ps
`default_nettype none
module pcs_flag_bank #(
    parameter int N = 5
) (
    input wire logic clock,
    input wire logic rst,
    pcs_flag_if.bank fl
);
    logic [N-1:0] flags_q;

    // ****************************************
    // Sticky flags
    // ****************************************
    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clock)
    begin
        if (rst)
            flags_q <= '0;
        else
            flags_q <= (flags_q & ~fl.clr) | fl.set;
    end

    assign fl.flags = flags_q;

    set_wins_a: assert property (@(posedge clock) disable iff (rst)
        |fl.set |-> ##1 ((fl.flags & $past(fl.set)) == $past(fl.set)))
        else $error("flag set lost");
    clr_zero_a: assert property (@(posedge clock) disable iff (rst)
        (fl.clr == '0 && fl.set == '0) |=> fl.flags == $past(fl.flags))
        else $error("flag changed without cause");

endmodule : pcs_flag_bank
`default_nettype wire

/* File: pcs_cmd_status.sv */
/*
 * Configuration command/status doubleword: command enables that gate
 * decoding, mastering and error reporting; status flags and fixed bits.
 * Assumes the PCI core delivers decoded address hits, parity results and
 * master events as one-cycle pulses synchronous to the PCI clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pcs_cmd_status (
    input wire logic clock,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic addr_valid,
    input wire logic addr_is_io,
    input wire logic addr_is_mem,
    input wire logic tx_done,
    output logic devsel_drive,
    output logic io_decode_en,
    output logic mem_decode_en,
    input wire logic mst_req,
    output logic mst_go,
    output logic [3:0] mst_write_cmd,
    input wire logic mst_active,
    input wire logic mst_mem_read,
    input wire logic mst_mem_write,
    input wire logic data_par_err,
    input wire logic addr_par_err,
    input wire logic tgt_perr_seen,
    input wire logic mst_abort_ev,
    input wire logic tgt_abort_ev,
    output logic perr_drive,
    output logic serr_drive
);
    import pcs_pkg::*;

    logic io_en_q;
    logic mem_en_q;
    logic master_en_q;
    logic par_resp_q;
    logic serr_en_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic perr_q;
    logic serr_q;
    logic [3:0] wcmd_q;
    logic [1:0] wait_q;
    pcs_tgt_e tgt_q;
    logic hit;
    logic wr_hit;
    logic [31:0] word;
    logic data_perr_ev;

    pcs_flag_if #(.N(PCS_NFLAGS)) fl ();

    pcs_flag_bank #(.N(PCS_NFLAGS)) u_flags (
        .clock(clock),
        .rst(rst),
        .fl(fl)
    );

    function automatic logic lane_bit(input logic [3:0] be, input int pos);
        lane_bit = be[pos / 8];
    endfunction : lane_bit

    assign wr_hit = cfg_wr && (cfg_addr == PCS_CMDSTAT_ADDR);

    // ****************************************
    // Command enables
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            io_en_q <= PCS_IO_EN_RST;
            mem_en_q <= PCS_MEM_EN_RST;
            master_en_q <= PCS_MASTER_EN_RST;
            par_resp_q <= PCS_PAR_RESP_RST;
            serr_en_q <= PCS_SERR_EN_RST;
        end
        else if (wr_hit)
        begin
            if (lane_bit(cfg_byte_en, PCS_B_IO_EN))
            begin
                io_en_q <= cfg_wdata[PCS_B_IO_EN];
                mem_en_q <= cfg_wdata[PCS_B_MEM_EN];
                master_en_q <= cfg_wdata[PCS_B_MASTER_EN];
                par_resp_q <= cfg_wdata[PCS_B_PAR_RESP];
            end
            if (lane_bit(cfg_byte_en, PCS_B_SERR_EN))
                serr_en_q <= cfg_wdata[PCS_B_SERR_EN];
        end
    end

    // ****************************************
    // Sticky status events
    // ****************************************
    // Own report on a read error, or the target's report on a write
    assign data_perr_ev = mst_active && par_resp_q &&
        ((mst_mem_read && data_par_err) || (mst_mem_write && tgt_perr_seen));

    always_comb
    begin
        fl.set = '0;
        fl.set[PCS_F_DATA_PERR] = data_perr_ev;
        fl.set[PCS_F_TGT_ABORT] = tgt_abort_ev;
        fl.set[PCS_F_MST_ABORT] = mst_abort_ev;
        fl.set[PCS_F_SIG_SERR] = addr_par_err && serr_en_q && par_resp_q;
        fl.set[PCS_F_DET_PERR] = data_par_err || addr_par_err;
        fl.clr = '0;
        if (wr_hit && lane_bit(cfg_byte_en, PCS_B_DATA_PERR))
        begin
            fl.clr[PCS_F_DATA_PERR] = cfg_wdata[PCS_B_DATA_PERR];
            fl.clr[PCS_F_TGT_ABORT] = cfg_wdata[PCS_B_TGT_ABORT];
            fl.clr[PCS_F_MST_ABORT] = cfg_wdata[PCS_B_MST_ABORT];
            fl.clr[PCS_F_SIG_SERR] = cfg_wdata[PCS_B_SIG_SERR];
            fl.clr[PCS_F_DET_PERR] = cfg_wdata[PCS_B_DET_PERR];
        end
    end

    // ****************************************
    // Read word assembly
    // ****************************************
    // Unlisted bits, including 21, 22, 7, 5, 3, 4 and 9, stay zero
    always_comb
    begin
        word = PCS_ZERO_WORD;
        word[PCS_B_IO_EN] = io_en_q;
        word[PCS_B_MEM_EN] = mem_en_q;
        word[PCS_B_MASTER_EN] = master_en_q;
        word[PCS_B_PAR_RESP] = par_resp_q;
        word[PCS_B_SERR_EN] = serr_en_q;
        word[PCS_B_CAP_LIST] = PCS_CAP_LIST_VAL;
        word[PCS_B_TGT_FBB] = PCS_TGT_FBB_VAL;
        word[PCS_B_DATA_PERR] = fl.flags[PCS_F_DATA_PERR];
        word[PCS_B_DEVSEL_HI:PCS_B_DEVSEL_LO] = PCS_DEVSEL_MEDIUM;
        word[PCS_B_MST_ABORT] = fl.flags[PCS_F_MST_ABORT];
        word[PCS_B_TGT_ABORT] = fl.flags[PCS_F_TGT_ABORT];
        word[PCS_B_SIG_SERR] = fl.flags[PCS_F_SIG_SERR];
        word[PCS_B_DET_PERR] = fl.flags[PCS_F_DET_PERR];
    end

    // Lanes not enabled and other offsets read as zero
    always_ff @(posedge clock)
    begin
        if (rst)
            rdata_q <= PCS_ZERO_WORD;
        else if (cfg_rd)
        begin
            for (int i = 0; i < 4; i++)
                rdata_q[i*8 +: 8] <= (cfg_addr == PCS_CMDSTAT_ADDR && cfg_byte_en[i]) ? word[i*8 +: 8] : 8'h00;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            ack_q <= 1'b0;
        else
            ack_q <= cfg_rd || cfg_wr;
    end

    assign cfg_rdata = rdata_q;
    assign cfg_ack = ack_q;

    // ****************************************
    // Target decode and claim timing
    // ****************************************
    assign hit = (addr_is_io && io_en_q) || (addr_is_mem && mem_en_q);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tgt_q <= PCS_T_IDLE;
            wait_q <= 2'h0;
        end
        else
        begin
            case (tgt_q)
                PCS_T_IDLE:
                begin
                    if (addr_valid && hit)
                    begin
                        tgt_q <= PCS_T_WAIT;
                        wait_q <= 2'h1;
                    end
                end
                PCS_T_WAIT:
                begin
                    wait_q <= wait_q + 2'h1;
                    if (wait_q == PCS_DEVSEL_CLOCKS - 2'h1)
                        tgt_q <= PCS_T_CLAIM;
                end
                PCS_T_CLAIM:
                begin
                    // Back-to-back address phase in the same cycle as the last data
                    if (tx_done && addr_valid && hit)
                    begin
                        tgt_q <= PCS_T_WAIT;
                        wait_q <= 2'h1;
                    end
                    else if (tx_done)
                        tgt_q <= PCS_T_IDLE;
                end
                default:
                    tgt_q <= PCS_T_IDLE;
            endcase
        end
    end

    assign devsel_drive = (tgt_q == PCS_T_CLAIM);
    assign io_decode_en = io_en_q;
    assign mem_decode_en = mem_en_q;

    // ****************************************
    // Master gating and error drivers
    // ****************************************
    assign mst_go = mst_req && master_en_q;

    // Constant command; invalidate variant never issued
    always_ff @(posedge clock)
    begin
        if (rst)
            wcmd_q <= PCS_CMD_MEM_WRITE;
        else
            wcmd_q <= PCS_CMD_MEM_WRITE;
    end
    assign mst_write_cmd = wcmd_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            perr_q <= 1'b0;
            serr_q <= 1'b0;
        end
        else
        begin
            perr_q <= data_par_err && par_resp_q;
            serr_q <= addr_par_err && serr_en_q && par_resp_q;
        end
    end
    assign perr_drive = perr_q;
    assign serr_drive = serr_q;

    // ****************************************
    // Checks
    // ****************************************
    devsel_medium_a: assert property (@(posedge clock) disable iff (rst)
        (tgt_q == PCS_T_IDLE && addr_valid && hit) |-> !devsel_drive ##1 !devsel_drive ##1 devsel_drive)
        else $error("claim not at medium timing");
    data_perr_gate_a: assert property (@(posedge clock) disable iff (rst)
        $rose(fl.flags[PCS_F_DATA_PERR]) |-> $past(mst_active && par_resp_q))
        else $error("data parity flag set outside master");
    data_perr_set_a: assert property (@(posedge clock) disable iff (rst)
        (mst_active && par_resp_q && ((mst_mem_read && data_par_err) || (mst_mem_write && tgt_perr_seen)))
        |=> fl.flags[PCS_F_DATA_PERR])
        else $error("data parity flag not set");
    fixed_bits_a: assert property (@(posedge clock) disable iff (rst)
        $past(cfg_rd && cfg_addr == PCS_CMDSTAT_ADDR && cfg_byte_en == 4'hF) |->
        (cfg_rdata[PCS_B_CAP_LIST] && cfg_rdata[PCS_B_TGT_FBB] && cfg_rdata[9] == 1'b0 && cfg_rdata[4] == 1'b0 &&
        cfg_rdata[PCS_B_DEVSEL_HI:PCS_B_DEVSEL_LO] == PCS_DEVSEL_MEDIUM))
        else $error("fixed bit wrong");
    serr_gate_a: assert property (@(posedge clock) disable iff (rst)
        serr_drive |-> $past(addr_par_err && serr_en_q && par_resp_q))
        else $error("system error without enables");
    perr_gate_a: assert property (@(posedge clock) disable iff (rst)
        (data_par_err && par_resp_q) |=> perr_drive)
        else $error("parity error not reported");
    master_gate_a: assert property (@(posedge clock) disable iff (rst)
        $past(wr_hit && lane_bit(cfg_byte_en, PCS_B_MASTER_EN) && !cfg_wdata[PCS_B_MASTER_EN]) |-> !mst_go)
        else $error("master without enable");
    decode_gate_a: assert property (@(posedge clock) disable iff (rst)
        (tgt_q == PCS_T_IDLE && addr_valid && !((addr_is_io && io_en_q) || (addr_is_mem && mem_en_q)))
        |=> tgt_q == PCS_T_IDLE)
        else $error("claimed a disabled space");
    serr_flag_a: assert property (@(posedge clock) disable iff (rst)
        serr_drive |-> fl.flags[PCS_F_SIG_SERR])
        else $error("system error flag missing");
    reset_cmd_a: assert property (@(posedge clock)
        $past(rst) |-> (io_en_q && mem_en_q && master_en_q && !par_resp_q && !serr_en_q && fl.flags == '0))
        else $error("command reset value wrong");

    claim_c: cover property (@(posedge clock) disable iff (rst) devsel_drive ##1 tx_done);
    fbb_c: cover property (@(posedge clock) disable iff (rst) tgt_q == PCS_T_CLAIM && tx_done && addr_valid && hit);
    serr_c: cover property (@(posedge clock) disable iff (rst) serr_drive);
    clear_c: cover property (@(posedge clock) disable iff (rst) fl.clr[PCS_F_DATA_PERR] && fl.flags[PCS_F_DATA_PERR]);

endmodule : pcs_cmd_status
`default_nettype wire

/* File: pcs_host_model.sv */
/*
 * Host side model: configuration software and the PCI core event sources.
 * Assumes the block under test samples on the rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module pcs_host_model (
    input wire logic clock,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata,
    output logic addr_valid,
    output logic addr_is_io,
    output logic addr_is_mem,
    output logic tx_done,
    output logic mst_req,
    output logic mst_active,
    output logic mst_mem_read,
    output logic mst_mem_write,
    output logic data_par_err,
    output logic addr_par_err,
    output logic tgt_perr_seen,
    output logic mst_abort_ev,
    output logic tgt_abort_ev,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack,
    input wire logic devsel_drive,
    input wire logic perr_drive,
    input wire logic serr_drive
);
    // ****************************************
    // Drivers, all moved on the falling edge
    // ****************************************
    initial
    begin
        {cfg_wr, cfg_rd, cfg_addr, cfg_byte_en, cfg_wdata} = 46'h0;
        {addr_valid, addr_is_io, addr_is_mem, tx_done, mst_req, mst_active} = 6'h0;
        {mst_mem_read, mst_mem_write, data_par_err, addr_par_err} = 4'h0;
        {tgt_perr_seen, mst_abort_ev, tgt_abort_ev} = 3'h0;
    end

    task automatic cfg_acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] d, output logic [31:0] rd, output logic ok);
        @(negedge clock);
        cfg_wr = wr;
        cfg_rd = !wr;
        cfg_addr = a;
        cfg_byte_en = be;
        cfg_wdata = d;
        @(negedge clock);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        // Released lines toggle so a stale value never passes
        cfg_addr = ~a;
        cfg_byte_en = ~be;
        cfg_wdata = ~d;
        ok = cfg_ack;
        rd = cfg_rdata;
    endtask : cfg_acc

    task automatic set_side(input logic [5:0] v);
        @(negedge clock);
        {mst_req, mst_active, mst_mem_read, mst_mem_write, addr_is_io, addr_is_mem} = v;
    endtask : set_side

    task automatic ev_pulse(input logic [4:0] v, output logic pe, output logic se);
        @(negedge clock);
        {data_par_err, addr_par_err, tgt_perr_seen, mst_abort_ev, tgt_abort_ev} = v;
        @(negedge clock);
        {data_par_err, addr_par_err, tgt_perr_seen, mst_abort_ev, tgt_abort_ev} = 5'h00;
        pe = perr_drive;
        se = serr_drive;
    endtask : ev_pulse

    task automatic claim(input logic b2b, output logic [4:0] seen);
        @(negedge clock);
        addr_valid = 1'b1;
        @(negedge clock);
        addr_valid = 1'b0;
        seen[0] = devsel_drive;
        @(negedge clock);
        seen[1] = devsel_drive;
        @(negedge clock);
        seen[2] = devsel_drive;
        tx_done = 1'b1;
        // Next address phase may ride on the last data phase
        addr_valid = b2b;
        @(negedge clock);
        tx_done = 1'b0;
        addr_valid = 1'b0;
        seen[3] = devsel_drive;
        @(negedge clock);
        seen[4] = devsel_drive;
        tx_done = b2b;
        @(negedge clock);
        tx_done = 1'b0;
    endtask : claim
endmodule : pcs_host_model
`default_nettype wire

/* File: testbench.sv */
/*
 * Self-checking bench for the command/status doubleword block.
 * Assumes the host model in its own file drives every block input except clock and reset.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pcs_pkg::*;
    // ****************************************
    // Signals and expectations
    // ****************************************
    localparam logic [31:0] FIXED = (32'(PCS_DEVSEL_MEDIUM) << PCS_B_DEVSEL_LO) |
        (32'(PCS_CAP_LIST_VAL) << PCS_B_CAP_LIST) | (32'(PCS_TGT_FBB_VAL) << PCS_B_TGT_FBB);
    localparam logic [31:0] RST_CMD = {29'h0, PCS_MASTER_EN_RST, PCS_MEM_EN_RST, PCS_IO_EN_RST};
    logic clock, rst, cfg_wr, cfg_rd, cfg_ack, addr_valid, addr_is_io, addr_is_mem, tx_done;
    logic devsel_drive, io_decode_en, mem_decode_en, mst_req, mst_go, mst_active;
    logic mst_mem_read, mst_mem_write, data_par_err, addr_par_err, tgt_perr_seen;
    logic mst_abort_ev, tgt_abort_ev, perr_drive, serr_drive, ok, pe, se;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_byte_en, mst_write_cmd;
    logic [4:0] seen;
    logic [31:0] cfg_wdata, cfg_rdata, exp_q, rd;
    integer seed;
    int miscompares = 0;
    int n_compared = 0;

    pcs_cmd_status u_pcs_cmd_status (.clock, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_byte_en,
        .cfg_wdata, .cfg_rdata, .cfg_ack, .addr_valid, .addr_is_io, .addr_is_mem, .tx_done,
        .devsel_drive, .io_decode_en, .mem_decode_en, .mst_req, .mst_go, .mst_write_cmd,
        .mst_active, .mst_mem_read, .mst_mem_write, .data_par_err, .addr_par_err, .tgt_perr_seen,
        .mst_abort_ev, .tgt_abort_ev, .perr_drive, .serr_drive);
    pcs_host_model u_pcs_host_model (.clock, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_byte_en, .cfg_wdata,
        .addr_valid, .addr_is_io, .addr_is_mem, .tx_done, .mst_req, .mst_active, .mst_mem_read,
        .mst_mem_write, .data_par_err, .addr_par_err, .tgt_perr_seen, .mst_abort_ev, .tgt_abort_ev,
        .cfg_rdata, .cfg_ack, .devsel_drive, .perr_drive, .serr_drive);

    initial
    begin
        clock = 1'b0;
    end
    always #12.5 clock = ~clock;

    // ****************************************
    // Expectation and checking helpers
    // ****************************************
    function automatic logic [31:0] after_wr(input logic [31:0] o, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] n;
        n = o;
        if (be[0])
        begin
            n[2:0] = d[2:0];
            n[6] = d[6];
        end
        if (be[1])
            n[8] = d[8];
        if (be[3])
            n[31:24] = n[31:24] & ~d[31:24];
        return n;
    endfunction : after_wr

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %08h expected %08h", $time, s, e);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        u_pcs_host_model.cfg_acc(1'b1, a, be, d, rd, ok);
        check(32'(ok), 32'h1);
        if (a == PCS_CMDSTAT_ADDR)
            exp_q = after_wr(exp_q, be, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [3:0] be);
        u_pcs_host_model.cfg_acc(1'b0, a, be, 32'h0, rd, ok);
        check(32'(ok), 32'h1);
        check(rd, (a == PCS_CMDSTAT_ADDR) ? (exp_q | FIXED) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} : 32'h0);
    endtask : rd_chk

    task automatic ev(input logic [4:0] v, input logic [31:0] f, input logic pe_e, input logic se_e);
        u_pcs_host_model.ev_pulse(v, pe, se);
        check({30'h0, pe, se}, {30'h0, pe_e, se_e});
        exp_q = exp_q | f;
        rd_chk(PCS_CMDSTAT_ADDR, 4'hF);
    endtask : ev

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        #1000000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        seed = 32'h242AFB2E;
        exp_q = RST_CMD;
        rst = 1'b1;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        rd_chk(PCS_CMDSTAT_ADDR, 4'hF);
        check({28'h0, mst_write_cmd}, {28'h0, PCS_CMD_MEM_WRITE});
        wr(8'h08, 4'hF, 32'hFFFFFFFF);
        rd_chk(8'h08, 4'hF);
        u_pcs_host_model.set_side(6'h20);
        // Random writes; only the writable command bits may move
        repeat (24)
        begin
            wr(PCS_CMDSTAT_ADDR, 4'($random(seed)), $random(seed));
            rd_chk(PCS_CMDSTAT_ADDR, 4'($random(seed)));
            check({29'h0, io_decode_en, mem_decode_en, mst_go}, {29'h0, exp_q[0], exp_q[1], exp_q[2]});
        end
        // Claims in each space, enable off and on; back-to-back claims in memory space
        for (int i = 0; i < 4; i++)
        begin
            wr(PCS_CMDSTAT_ADDR, 4'h1, {30'h1, i[0] & i[1], i[0] & !i[1]});
            u_pcs_host_model.set_side({4'h8, !i[1], i[1]});
            u_pcs_host_model.claim(i[1], seen);
            check({27'h0, seen}, {27'h0, i[0] ? (i[1] ? 5'h16 : 5'h06) : 5'h00});
        end
        wr(PCS_CMDSTAT_ADDR, 4'h3, 32'h00000107);
        ev(5'h08, 32'h80000000, 1'b0, 1'b0);
        ev(5'h10, 32'h80000000, 1'b0, 1'b0);
        wr(PCS_CMDSTAT_ADDR, 4'hF, 32'hF1000147);
        ev(5'h08, 32'hC0000000, 1'b0, 1'b1);
        ev(5'h10, 32'h80000000, 1'b1, 1'b0);
        u_pcs_host_model.set_side(6'h38);
        ev(5'h10, 32'h81000000, 1'b1, 1'b0);
        wr(PCS_CMDSTAT_ADDR, 4'h8, 32'h01000000);
        rd_chk(PCS_CMDSTAT_ADDR, 4'hF);
        u_pcs_host_model.set_side(6'h34);
        ev(5'h04, 32'h01000000, 1'b0, 1'b0);
        wr(PCS_CMDSTAT_ADDR, 4'h9, 32'h01000007);
        ev(5'h04, 32'h0, 1'b0, 1'b0);
        ev(5'h01, 32'h10000000, 1'b0, 1'b0);
        ev(5'h02, 32'h20000000, 1'b0, 1'b0);
        // Reset in mid-run restores defaults
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        exp_q = RST_CMD;
        rd_chk(PCS_CMDSTAT_ADDR, 4'hF);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
